// file: src/mmbm_pkg.sv
// Shared widths, register map, reset values and carrier types for the
// memory-mapped bus master port.
// Assumes one clock domain shared by the port, the design logic on the
// inside and the system interconnect on the outside.
package mmbm_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int BE_W     = (DATA_W > 8) ? DATA_W / 8 : 1;
  localparam int BURST_W  = 4;
  localparam int IRQN_W   = 6;
  localparam int PEND_W   = 8;

  // ----------------------------------------------------------------
  // Access types of the port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MMBM_ACC_READ,
    MMBM_ACC_WRITE,
    MMBM_ACC_RW
  } mmbm_access_t;

  // ----------------------------------------------------------------
  // Control register port
  // ----------------------------------------------------------------
  localparam int          REG_AW       = 8;
  localparam int          REG_DW       = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_XFER_CNT = 8'h08;
  // Control fields
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_FLUSH    = 1;
  localparam int CTRL_EOP_CLR  = 2;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  // Status fields
  localparam int STAT_BUSY     = 0;
  localparam int STAT_EOP      = 1;
  localparam int STAT_IRQ      = 2;
  localparam int STAT_FLUSHING = 3;
  localparam int STAT_PEND_LSB = 8;
  localparam int STAT_IRQN_LSB = 16;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Command from the design logic
  typedef struct packed {
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [BE_W-1:0]     be;
    logic [BURST_W-1:0]  burst;
  } mmbm_cmd_t;

  // Master outputs towards the interconnect
  typedef struct packed {
    logic [ADDR_W-1:0]   address;
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   writedata;
    logic [BE_W-1:0]     byteenable;
    logic [BURST_W-1:0]  burstcount;
    logic                flush;
  } mmbm_bus_req_t;

  // Inputs from the interconnect
  typedef struct packed {
    logic                waitrequest;
    logic [DATA_W-1:0]   readdata;
    logic                readdatavalid;
    logic                endofpacket;
    logic                irq;
    logic [IRQN_W-1:0]   irqnumber;
  } mmbm_bus_rsp_t;

endpackage : mmbm_pkg

// file: src/mmbm_pend_ctr.sv
// Counter of read beats still owed by the slave side in pipelined mode.
// Assumes add and take may coincide; clear discards everything owed.
module mmbm_pend_ctr
  import mmbm_pkg::*;
#(
  parameter int W = PEND_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         add,
  input  wire logic [W-1:0] add_val,
  input  wire logic         take,
  input  wire logic         clear,
  output logic      [W-1:0] count
);

  // ----------------------------------------------------------------
  // Owed-beat count
  // ----------------------------------------------------------------
  logic [W-1:0] next_count;

  // A take with nothing owed is a stray beat and is not counted
  always_comb begin
    next_count = count;
    if (add)
      next_count = next_count + add_val;
    if (take && count != '0)
      next_count = next_count - W'(1);
  end

  // Clear drops all owed beats at once
  always_ff @(posedge clk) begin
    if (rst || clear)
      count <= '0;
    else
      count <= next_count;
  end

endmodule : mmbm_pend_ctr

// file: src/mmbm_master.sv
// Memory-mapped bus master port: turns commands of the design logic into
// read and write transfers on the system interconnect.
// Assumes the interconnect runs on clk and answers with waitrequest and,
// in pipelined mode, readdatavalid; software reaches a few control
// registers over a plain strobe port.
//
// Behaviour
// - Hold the transfer while waitrequest is high; advance once it drops.
// - Address is a byte address always aligned to a data word.
// - Read request exists only for read or read-write ports.
// - Read data is taken from readdata on read-capable ports.
// - Write request exists only for write or read-write ports.
// - Write data is driven on writedata on write-capable ports.
// - Byte enables for writes when write-capable and data wider than 8.
// - All byte enables are active during every read.
// - With flow control the slave signals end of packet on endofpacket.
// - Pipelined reads capture readdata only when readdatavalid is high.
// - With pipelining and flush enabled, flush discards pending reads.
// - With bursts enabled, burstcount gives the beats of the burst.
//
// Local design decisions: the strobed register port and the register offsets.
module mmbm_master
  import mmbm_pkg::*;
#(
  parameter mmbm_access_t ACCESS    = MMBM_ACC_RW,
  parameter bit           BYTE_EN   = 1'b1,
  parameter bit           FLOW_CTRL = 1'b1,
  parameter bit           PIPELINE  = 1'b1,
  parameter bit           FLUSH_EN  = 1'b1,
  parameter bit           BURST_EN  = 1'b1
) (
  input  wire logic                clk,
  input  wire logic                rst,
  // Design-side command and read answer
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire mmbm_cmd_t           cmd,
  output logic                     rsp_valid,
  output logic      [DATA_W-1:0]   rsp_data,
  // Interconnect side
  output mmbm_bus_req_t            bus_req,
  input  wire mmbm_bus_rsp_t       bus_rsp,
  // Control register port
  input  wire logic [REG_AW-1:0]   reg_addr,
  input  wire logic [REG_DW-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [REG_DW-1:0]   reg_rdata
);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  localparam bit CAN_RD  = (ACCESS != MMBM_ACC_WRITE);
  localparam bit CAN_WR  = (ACCESS != MMBM_ACC_READ);
  localparam bit USE_BE  = CAN_WR && BYTE_EN && (DATA_W > 8);
  localparam bit PIPE    = PIPELINE && CAN_RD;
  localparam bit USE_FL  = PIPE && FLUSH_EN;
  localparam logic [ADDR_W-1:0]  LSB_MASK  = ADDR_W'(BE_W - 1);
  localparam logic [BURST_W-1:0] ONE_BEAT  = BURST_W'(1);

  typedef enum logic [1:0] {
    MMBM_IDLE,
    MMBM_XFER,
    MMBM_WDATA
  } mmbm_state_t;

  // Word-align a byte address by clearing the lane bits
  function automatic logic [ADDR_W-1:0] word_align(
    input logic [ADDR_W-1:0] a
  );
    word_align = a & ~LSB_MASK;
  endfunction : word_align

  // Bursts of zero or without burst support collapse to one beat
  function automatic logic [BURST_W-1:0] beats(
    input logic [BURST_W-1:0] b,
    input logic               is_wr
  );
    if (!BURST_EN || b == '0 || (!is_wr && !PIPE))
      beats = ONE_BEAT;
    else
      beats = b;
  endfunction : beats

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mmbm_state_t          state;
  mmbm_bus_req_t        req;
  logic [BURST_W-1:0]   beats_left;
  logic                 enable;
  logic                 flush_req;
  logic                 flush_pulse;
  logic                 eop_seen;
  logic [REG_DW-1:0]    xfer_cnt;
  logic [PEND_W-1:0]    pend;
  logic                 take_cmd;
  logic                 accepted;
  logic                 rd_capture;

  // A new command is taken when idle, enabled and no flush is pending or issued; further burst data beats are taken in MMBM_WDATA
  assign cmd_ready = (state == MMBM_IDLE && enable && !flush_req
                      && !flush_pulse)
                     || state == MMBM_WDATA;
  assign take_cmd  = cmd_valid && cmd_ready;
  // The slave has taken the current beat once waitrequest is low
  assign accepted  = state == MMBM_XFER && !bus_rsp.waitrequest;

  // Unused lines are tied off instead of removed
  always_comb begin
    bus_req            = req;
    bus_req.read       = CAN_RD ? req.read : 1'b0;
    bus_req.write      = CAN_WR ? req.write : 1'b0;
    bus_req.writedata  = CAN_WR ? req.writedata : '0;
    bus_req.burstcount = BURST_EN ? req.burstcount : ONE_BEAT;
    bus_req.flush      = USE_FL ? flush_pulse : 1'b0;
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Outputs change only on a take or an acceptance, so they hold
  // through every waitrequest cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= MMBM_IDLE;
      req        <= '0;
      beats_left <= '0;
    end else begin
      case (state)
        MMBM_IDLE: begin
          if (take_cmd) begin
            req.address    <= word_align(cmd.addr);
            req.read       <= CAN_RD && !(CAN_WR && cmd.wr);
            req.write      <= CAN_WR && (cmd.wr || !CAN_RD);
            req.writedata  <= cmd.wdata;
            // Reads always enable every lane
            req.byteenable <= (USE_BE && (cmd.wr || !CAN_RD))
                              ? cmd.be : '1;
            req.burstcount <= beats(cmd.burst, cmd.wr || !CAN_RD);
            beats_left     <= beats(cmd.burst, cmd.wr || !CAN_RD)
                              - ONE_BEAT;
            state          <= MMBM_XFER;
          end
        end
        MMBM_XFER: begin
          if (accepted) begin
            if (req.write && beats_left != '0) begin
              // Further burst beats wait for their data
              req.write  <= 1'b0;
              state      <= MMBM_WDATA;
            end else begin
              req.read   <= 1'b0;
              req.write  <= 1'b0;
              state      <= MMBM_IDLE;
            end
          end
        end
        MMBM_WDATA: begin
          if (take_cmd) begin
            req.writedata  <= cmd.wdata;
            req.byteenable <= USE_BE ? cmd.be : '1;
            req.write      <= 1'b1;
            beats_left     <= beats_left - ONE_BEAT;
            state          <= MMBM_XFER;
          end
        end
        default: state <= MMBM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Pipelined reads trust readdatavalid only while beats are owed, so a
  // late beat after a flush is dropped
  assign rd_capture = PIPE ? (bus_rsp.readdatavalid && pend != '0)
                           : (CAN_RD && accepted && req.read);

  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= rd_capture;
      if (rd_capture)
        rsp_data <= bus_rsp.readdata;
    end
  end

  mmbm_pend_ctr #(
    .W       (PEND_W)
  ) u_pend (
    .clk     (clk),
    .rst     (rst),
    .add     (PIPE && accepted && req.read),
    .add_val (PEND_W'(req.burstcount)),
    .take    (rd_capture),
    .clear   (USE_FL && flush_pulse),
    .count   (pend)
  );

  // ----------------------------------------------------------------
  // Flush
  // ----------------------------------------------------------------
  // Requested by software, issued as one pulse once no request is open
  always_ff @(posedge clk) begin
    if (rst) begin
      flush_req   <= 1'b0;
      flush_pulse <= 1'b0;
    end else begin
      flush_pulse <= 1'b0;
      if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_FLUSH] && USE_FL)
        flush_req <= 1'b1;
      else if (flush_req && state == MMBM_IDLE) begin
        flush_req   <= 1'b0;
        flush_pulse <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  // Enable gates new commands only; an open transfer always completes
  always_ff @(posedge clk) begin
    if (rst)
      enable <= CTRL_ENABLE_RST;
    else if (reg_wr && reg_addr == OFS_CTRL)
      enable <= reg_wdata[CTRL_ENABLE];
  end

  // Sticky end-of-packet; a new one in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst)
      eop_seen <= 1'b0;
    else if (FLOW_CTRL && bus_rsp.endofpacket)
      eop_seen <= 1'b1;
    else if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_EOP_CLR])
      eop_seen <= 1'b0;
  end

  // Count of accepted requests, one per write beat and one per read command, wraps silently
  always_ff @(posedge clk) begin
    if (rst)
      xfer_cnt <= '0;
    else if (accepted && (req.read || req.write))
      xfer_cnt <= xfer_cnt + REG_DW'(1);
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else if (reg_addr == OFS_CTRL) begin
      reg_rdata              <= '0;
      reg_rdata[CTRL_ENABLE] <= enable;
      reg_rdata[CTRL_FLUSH]  <= flush_req;
    end else if (reg_addr == OFS_STATUS) begin
      reg_rdata                <= '0;
      reg_rdata[STAT_BUSY]     <= state != MMBM_IDLE || pend != '0;
      reg_rdata[STAT_EOP]      <= eop_seen;
      reg_rdata[STAT_IRQ]      <= bus_rsp.irq;
      reg_rdata[STAT_FLUSHING] <= flush_req;
      reg_rdata[STAT_PEND_LSB +: PEND_W] <= pend;
      // Priority number is meaningful only while irq is high
      reg_rdata[STAT_IRQN_LSB +: IRQN_W] <= bus_rsp.irq
                                            ? bus_rsp.irqnumber : '0;
    end else if (reg_addr == OFS_XFER_CNT)
      reg_rdata <= xfer_cnt;
    else
      reg_rdata <= '0;
  end

endmodule : mmbm_master

// file: sim/mmbm_master_properties.sv
// Concurrent checks on the ports of the bus master port.
// Assumes one clock and a synchronous active-high reset.
module mmbm_master_properties
  import mmbm_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire mmbm_cmd_t         cmd,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire mmbm_bus_req_t     bus_req,
  input wire mmbm_bus_rsp_t     bus_rsp
);
  logic req;
  logic take;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Helpers: a command taken while no request is on the bus
  // ------------------------------------------------------------
  assign req  = bus_req.read | bus_req.write;
  assign take = cmd_valid & cmd_ready & ~req;

  AST_STALL_HOLD:
    assert property (req && bus_rsp.waitrequest |=>
      $stable(bus_req[$bits(bus_req)-1:1]))
    else $error("request changed during a stall");
  AST_ALIGN:
    assert property (req |-> bus_req.address % BE_W == 0)
    else $error("address not word aligned");
  AST_READ_LANES:
    assert property (bus_req.read |-> &bus_req.byteenable)
    else $error("read without all byte lanes");
  AST_ONE_DIR:
    assert property (!(bus_req.read && bus_req.write))
    else $error("read and write together");
  AST_ISSUE:
    assert property (take |=> bus_req.write == $past(cmd.wr)
      && bus_req.read == !$past(cmd.wr))
    else $error("taken command not issued next cycle");
  AST_WR_FIELDS:
    assert property (take && cmd.wr |=>
      bus_req.writedata == $past(cmd.wdata)
      && bus_req.byteenable == $past(cmd.be))
    else $error("write data or lanes differ from command");
  AST_BURST:
    assert property (take && !cmd.wr |=> bus_req.burstcount ==
      ($past(cmd.burst) == 0 ? BURST_W'(1) : $past(cmd.burst)))
    else $error("burst count differs from command");
  AST_CAPTURE:
    assert property (rsp_valid |-> $past(bus_rsp.readdatavalid)
      && rsp_data == $past(bus_rsp.readdata))
    else $error("read answer without a valid beat");
  AST_FLUSH_PULSE:
    assert property (bus_req.flush |=> !bus_req.flush)
    else $error("flush longer than one cycle");
  AST_PROCEED:
    assert property (bus_req.write && !bus_rsp.waitrequest
      && bus_req.burstcount == 1 |=> !bus_req.write)
    else $error("single write not released after acceptance");
endmodule : mmbm_master_properties

bind mmbm_master mmbm_master_properties u_mmbm_master_properties (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .bus_req(bus_req), .bus_rsp(bus_rsp));

// file: sim/mmbm_slave_model.sv
// Behavioural slave on the interconnect side of the bus master port.
// Assumes pipelined reads; stall, hold and interrupt come from the bench.
module mmbm_slave_model
  import mmbm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire mmbm_bus_req_t     bus_req,
  input  wire logic [1:0]        stall,
  input  wire logic              hold,
  input  wire logic              irq,
  input  wire logic [IRQN_W-1:0] irqn,
  output mmbm_bus_rsp_t          bus_rsp
);
  logic [1:0]        wcnt;
  logic [DATA_W:0]   owed[$];
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic              eop;
  logic              req;
  logic              wait_now;

  // Each request waits stall cycles before acceptance
  assign req      = bus_req.read | bus_req.write;
  assign wait_now = req && wcnt != stall;
  assign bus_rsp  = '{waitrequest: wait_now, readdata: rdata,
                      readdatavalid: rvalid, endofpacket: eop,
                      irq: irq, irqnumber: irqn};

  // ------------------------------------------------------------
  // Read beats owed; every other cycle at best, so latency varies
  // ------------------------------------------------------------
  always @(posedge clk) begin
    wcnt <= (rst || !wait_now) ? 2'd0 : wcnt + 2'd1;
    if (rst || bus_req.flush) begin
      owed.delete();
    end else if (bus_req.read && !wait_now) begin
      for (int i = 0; i < bus_req.burstcount; i++) begin
        owed.push_back({i == bus_req.burstcount - 1,
                        bus_req.address + DATA_W'(4 * i)});
      end
    end
    // Idle data lines toggle so a stale word is never mistaken
    if (rst) begin
      rdata  <= '0;
      rvalid <= 1'b0;
      eop    <= 1'b0;
    end else if (owed.size() > 0 && !hold && !rvalid) begin
      {eop, rdata} <= owed.pop_front();
      rvalid       <= 1'b1;
    end else begin
      rdata  <= ~rdata;
      rvalid <= 1'b0;
      eop    <= 1'b0;
    end
  end
endmodule : mmbm_slave_model

// file: sim/test_mm_bus_master_port.sv
// Self-checking bench of the bus master port against the slave model.
// Assumes the default port parameters: read-write, pipelined, bursts.
module test_mm_bus_master_port
  import mmbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cmd_valid = 1'b0;
  logic              cmd_ready;
  mmbm_cmd_t         cmd = '0;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  mmbm_bus_req_t     bus_req;
  mmbm_bus_rsp_t     bus_rsp;
  logic [7:0]        reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic [1:0]        stall = '0;
  logic              hold = 1'b0;
  logic              irq = 1'b0;
  logic [5:0]        irqn = '0;
  logic [31:0]       seed = 32'h7323;
  logic [67:0]       wq[$];
  logic [67:0]       w;
  logic [31:0]       dq[$];
  logic [31:0]       rq[$];
  logic              rd_d = 1'b0;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                flushes = 0;
  int                n_beats = 0;

  always #10 clk = ~clk;

  mmbm_master u_mmbm_master (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mmbm_slave_model u_mmbm_slave_model (.clk(clk), .rst(rst),
    .bus_req(bus_req), .stall(stall), .hold(hold), .irq(irq),
    .irqn(irqn), .bus_rsp(bus_rsp));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic reg_io(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    if (!wr) rq.push_back(d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // One idle edge so the next call never re-raises a strobe at once
    @(posedge clk);
  endtask : reg_io

  // Offer one command and, for a burst write, each further data beat;
  // note what the bus must show; every wait is bounded
  task automatic send(input logic wr, input logic [31:0] a, d,
                      input logic [3:0] be, n);
    int          k;
    logic [31:0] aw;
    aw = {a[31:2], 2'b00};
    n_beats += wr ? int'(n) : 1;
    for (int i = 0; i < n && !wr; i++) dq.push_back(aw + 4 * i);
    cmd_valid <= 1'b1;
    for (int j = 0; j < (wr ? n : 1); j++) begin
      // Raw address goes out; the bus must show it word aligned
      cmd <= '{wr: wr, addr: a, wdata: d, be: be, burst: n};
      if (wr) wq.push_back({aw, d, be});
      for (k = 0; k < 200 && !(k > 0 && cmd_ready); k++) @(negedge clk);
      if (k == 200) begin
        n_mismatch++;
        close_out();
      end
      @(posedge clk);
      d  = rnd();
      be = 4'(rnd());
    end
    // Valid stays up between beats; an idle edge follows the command
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask : send

  task automatic drain();
    int k;
    for (k = 0; k < 500 && wq.size() + dq.size() > 0; k++) @(posedge clk);
    if (k == 500) begin
      n_mismatch++;
      close_out();
    end
    repeat (3) @(posedge clk);
  endtask : drain

  // ------------------------------------------------------------
  // Result watcher: oldest noted expectation against each result
  // ------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (bus_req.flush) flushes++;
    if (rsp_valid) chk("rsp_data", dq.pop_front(), rsp_data);
    if (bus_req.write && !bus_rsp.waitrequest) begin
      w = wq.pop_front();
      chk("address", w[67:36], bus_req.address);
      chk("writedata", w[35:4], bus_req.writedata);
      chk("byteenable", 32'(w[3:0]), 32'(bus_req.byteenable));
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reg_io(1'b0, OFS_CTRL, 32'h1);
    reg_io(1'b1, 8'h0c, 32'hffff);
    reg_io(1'b0, 8'h0c, 32'h0);
    // Mixed traffic with random stalls, odd addresses and random read lanes
    for (int i = 0; i < 12; i++) begin
      stall <= 2'(rnd());
      send(i[0], rnd(), rnd(), 4'(rnd()), 4'(rnd() % 3 + 1));
    end
    drain();
    reg_io(1'b0, OFS_XFER_CNT, 32'(n_beats));
    irq  <= 1'b1;
    irqn <= 6'h2a;
    reg_io(1'b0, OFS_STATUS, 32'h002a0006);
    reg_io(1'b1, OFS_CTRL, 32'h5);
    irq <= 1'b0;
    reg_io(1'b0, OFS_STATUS, 32'h0);
    // Owed beats held back, then discarded by a flush
    hold  <= 1'b1;
    stall <= 2'd0;
    send(1'b0, 32'h100, 32'h0, 4'h0, 4'h4);
    repeat (3) @(posedge clk);
    reg_io(1'b0, OFS_STATUS, 32'h0401);
    reg_io(1'b1, OFS_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    reg_io(1'b0, OFS_STATUS, 32'h0);
    dq.delete();
    hold <= 1'b0;
    chk("flush", 32'd1, 32'(flushes));
    // Disabled port refuses commands until enabled again
    reg_io(1'b1, OFS_CTRL, 32'h0);
    chk("cmd_ready", 32'h0, 32'(cmd_ready));
    reg_io(1'b0, OFS_CTRL, 32'h0);
    reg_io(1'b1, OFS_CTRL, 32'h1);
    send(1'b0, 32'h204, 32'h0, 4'h0, 4'h2);
    drain();
    close_out();
  end
endmodule : test_mm_bus_master_port
